// file: src/lane_err_consts.vh
`ifndef LANE_ERR_CONSTS_VH
`define LANE_ERR_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_W 12
`define DATA_W 8
`define ADDR_INVALID_CODE_STATUS 12'h46E
`define ADDR_STRAY_CONTROL_STATUS 12'h46F
`define ADDR_IRQ_STATUS 12'h480
`define ADDR_IRQ_MASK 12'h481
`define ADDR_COUNT_CLEAR 12'h482

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define IRQ_BIT_INVALID_CODE 0
`define IRQ_BIT_STRAY_CONTROL 1
`define COUNT_CLEAR_BIT 0
`define STATUS_RESET 8'h00
`define IRQ_MASK_RESET 8'h00
`define READ_UNMAPPED 8'h00

`endif

// file: src/lane_err_counter.v
`timescale 1ns/100ps
// ----------------------------------------
// One error counter and its threshold flag
// ----------------------------------------
module lane_err_counter #(
   parameter CNT_W = 8
) (
   input wire ref_clk, // System clock
   input wire reset_n, // Async reset, active low
   input wire err_evt, // One detected error, pulse
   input wire clear, // Zero the count, pulse
   input wire [CNT_W-1:0] threshold, // Error count threshold
   output reg [CNT_W-1:0] count_r, // Current error count
   output reg flag_r // Count at or above threshold
);

   localparam [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
   localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

   // Saturating count of errors, clear has priority
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         count_r <= {CNT_W{1'b0}};
      end else if (clear) begin
         count_r <= {CNT_W{1'b0}};
      end else if (err_evt && (count_r != CNT_MAX)) begin
         count_r <= count_r + CNT_ONE;
      end
   end

   // Threshold compare, flag zero during reset
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         flag_r <= 1'b0;
      end else begin
         flag_r <= (count_r >= threshold);
      end
   end

endmodule // lane_err_counter

// file: src/lane_code_error_status.v
`timescale 1ns/100ps
`include "lane_err_consts.vh"

module lane_code_error_status #(
   parameter NUM_LANES = 8,
   parameter NUM_LINKS = 2,
   parameter PAGE_W = 1,
   parameter CNT_W = 8
) (
   input wire ref_clk, // System clock, 10 MHz
   input wire reset_n, // Async reset, active low
   input wire [NUM_LINKS*NUM_LANES-1:0] invalid_code_evt, // Code not in table, per link/lane
   input wire [NUM_LINKS*NUM_LANES-1:0] stray_control_evt, // Unexpected control char, per link/lane
   input wire [CNT_W-1:0] error_count_threshold, // Shared error threshold
   input wire [PAGE_W-1:0] link_page, // Link select for the flags
   input wire [`ADDR_W-1:0] reg_addr, // Register address
   input wire [`DATA_W-1:0] reg_wdata, // Register write data
   input wire reg_wr, // Write strobe
   input wire reg_rd, // Read strobe
   output reg [`DATA_W-1:0] reg_rdata_r, // Read data, cycle after strobe
   output wire irq // Level interrupt, active high
);

   localparam NL = NUM_LINKS * NUM_LANES;

   // Flat event and flag vectors, link-major:
   // bit link*NUM_LANES+lane, two counters per bit,
   // one for each error class

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   wire [NL-1:0] invalid_flag;
   wire [NL-1:0] stray_flag;
   reg [NL-1:0] invalid_flag_d_r;
   reg [NL-1:0] stray_flag_d_r;
   reg [NUM_LANES-1:0] invalid_page;
   reg [NUM_LANES-1:0] stray_page;
   reg [`DATA_W-1:0] irq_status_r;
   reg [`DATA_W-1:0] irq_status_nxt;
   reg [`DATA_W-1:0] irq_mask_r;
   reg count_clear_r;
   reg [`DATA_W-1:0] rdata_nxt;
   wire invalid_rise;
   wire stray_rise;
   wire wr_status;
   wire wr_mask;
   wire wr_clear;

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   // Lane flags of one link, zero if page out of range
   function [NUM_LANES-1:0] page_flags;
      input [NL-1:0] flags; // All links, link-major
      input [PAGE_W-1:0] page; // Selected link
      integer j;
      begin
         page_flags = {NUM_LANES{1'b0}};
         for (j = 0; j < NUM_LINKS; j = j + 1) begin
            if (page == j[PAGE_W-1:0]) begin
               page_flags = flags[j*NUM_LANES +: NUM_LANES];
            end
         end
      end
   endfunction

   // Any flag of one class gone from 0 to 1
   function any_rise;
      input [NL-1:0] now_flags; // Flags this cycle
      input [NL-1:0] old_flags; // Flags one cycle back
      begin
         any_rise = |(now_flags & ~old_flags);
      end
   endfunction

   // ----------------------------------------
   // Counters, one per link, lane and class
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < NL; g = g + 1) begin : g_lane
         // Invalid code group counter
         lane_err_counter #(.CNT_W(CNT_W)) u_invalid (
            .ref_clk(ref_clk),
            .reset_n(reset_n),
            .err_evt(invalid_code_evt[g]),
            .clear(count_clear_r),
            .threshold(error_count_threshold),
            .count_r(),
            .flag_r(invalid_flag[g])
         );
         // Unexpected control character counter
         lane_err_counter #(.CNT_W(CNT_W)) u_stray (
            .ref_clk(ref_clk),
            .reset_n(reset_n),
            .err_evt(stray_control_evt[g]),
            .clear(count_clear_r),
            .threshold(error_count_threshold),
            .count_r(),
            .flag_r(stray_flag[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // Link paging of the flags
   // ----------------------------------------
   // Pick the lane flags of the selected link, zero if out of range
   always @* begin
      invalid_page = page_flags(invalid_flag, link_page);
      stray_page = page_flags(stray_flag, link_page);
   end

   // ----------------------------------------
   // Interrupt events and status
   // ----------------------------------------
   // Previous flags for rising-edge detect
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         invalid_flag_d_r <= {NL{1'b0}};
         stray_flag_d_r <= {NL{1'b0}};
      end else begin
         invalid_flag_d_r <= invalid_flag;
         stray_flag_d_r <= stray_flag;
      end
   end

   // ----------------------------------------
   // Edge events and write decode
   // ----------------------------------------
   // Flags rechecked each cycle: a lower threshold
   // raises flags, and maybe the interrupt,
   // with no new errors
   assign invalid_rise = any_rise(invalid_flag, invalid_flag_d_r);
   assign stray_rise = any_rise(stray_flag, stray_flag_d_r);
   // One write strobe per writable register
   assign wr_status = reg_wr && (reg_addr == `ADDR_IRQ_STATUS);
   assign wr_mask = reg_wr && (reg_addr == `ADDR_IRQ_MASK);
   assign wr_clear = reg_wr && (reg_addr == `ADDR_COUNT_CLEAR);

   // Status bit 0: some code flag rose
   // Status bit 1: some control flag rose

   // Write one to clear, a new event wins over the clear
   always @* begin
      irq_status_nxt = irq_status_r;
      if (wr_status) begin
         irq_status_nxt = irq_status_r & ~reg_wdata;
      end
      if (invalid_rise) begin
         irq_status_nxt[`IRQ_BIT_INVALID_CODE] = 1'b1;
      end
      if (stray_rise) begin
         irq_status_nxt[`IRQ_BIT_STRAY_CONTROL] = 1'b1;
      end
      irq_status_nxt[`DATA_W-1:2] = {(`DATA_W-2){1'b0}};
   end

   // Status, mask and counter clear registers
   // Clear pulse comes a cycle after the write;
   // errors in that cycle are dropped
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_status_r <= `STATUS_RESET;
         irq_mask_r <= `IRQ_MASK_RESET;
         count_clear_r <= 1'b0;
      end else begin
         irq_status_r <= irq_status_nxt;
         if (wr_mask) begin
            irq_mask_r <= {{(`DATA_W-2){1'b0}}, reg_wdata[1:0]};
         end
         count_clear_r <= wr_clear && reg_wdata[`COUNT_CLEAR_BIT];
      end
   end

   assign irq = |(irq_status_r & irq_mask_r);

   // ----------------------------------------
   // Register read port
   // ----------------------------------------
   // Map, all registers 8 bits wide
   //   0x46E  code flags, lane n at bit n, RO
   //   0x46F  control flags, lane n at bit n, RO
   //   0x480  irq status, W1C, set wins
   //   0x481  irq mask, bits 1:0, rest read 0
   //   0x482  bit0 = 1 clears every counter
   // Flags follow the link page
   // Unmapped reads give 0, unmapped writes ignored

   // Read decode, status flags have no write path
   always @* begin
      rdata_nxt = `READ_UNMAPPED;
      case (reg_addr)
         `ADDR_INVALID_CODE_STATUS: rdata_nxt = invalid_page[`DATA_W-1:0];
         `ADDR_STRAY_CONTROL_STATUS: rdata_nxt = stray_page[`DATA_W-1:0];
         `ADDR_IRQ_STATUS: rdata_nxt = irq_status_r;
         `ADDR_IRQ_MASK: rdata_nxt = irq_mask_r;
         `ADDR_COUNT_CLEAR: rdata_nxt = `READ_UNMAPPED; // Write-only pulse
         default: rdata_nxt = `READ_UNMAPPED;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata_r <= `READ_UNMAPPED;
      end else if (reg_rd) begin
         reg_rdata_r <= rdata_nxt;
      end else begin
         reg_rdata_r <= `READ_UNMAPPED;
      end
   end

endmodule // lane_code_error_status

// file: tb/lane_err_src.sv
`timescale 1ns/100ps
// ----------------------------------------
// Far-end lane error source
// ----------------------------------------
module lane_err_src (
   input wire ref_clk, // Clock
   input wire [4:0] sel, // Class, link and lane
   input wire [7:0] n, // Errors to send
   input wire go, // Start pulse
   output logic [15:0] code_evt = 16'h0000, // Code errors
   output logic [15:0] ctrl_evt = 16'h0000 // Control errors
);
   logic [7:0] left_r = 8'h00;
   logic hit;
   assign hit = left_r != 8'h00;
   // One error each cycle, quiet once done
   always @(posedge ref_clk) begin
      left_r <= go ? n : (hit ? left_r - 8'h01 : 8'h00);
      code_evt <= (hit && !sel[4]) ? 16'h0001 << sel[3:0] : 16'h0000;
      ctrl_evt <= (hit && sel[4]) ? 16'h0001 << sel[3:0] : 16'h0000;
   end
endmodule // lane_err_src

// file: tb/lane_err_asserts.sv
`timescale 1ns/100ps
`include "lane_err_consts.vh"
module lane_err_asserts #(
   parameter CNT_W = 8
) (
   input wire ref_clk, // Clock
   input wire reset_n, // Reset
   input wire [CNT_W-1:0] error_count_threshold, // Threshold
   input wire [`ADDR_W-1:0] reg_addr, // Address
   input wire [`DATA_W-1:0] reg_wdata, // Write data
   input wire reg_wr, // Write
   input wire reg_rd, // Read
   input wire [`DATA_W-1:0] reg_rdata_r, // Read data
   input wire irq // Interrupt
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // Read port, irq mask and threshold checks
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_r == 8'h00)
      else $error("read data not idle");
   a_unmapped_zero: assert property (reg_rd && !(reg_addr inside {12'h46E, 12'h46F, 12'h480, 12'h481})
      |=> reg_rdata_r == 8'h00) else $error("unmapped read not zero");
   a_irq_upper: assert property (reg_rd && reg_addr inside {12'h480, 12'h481} |=> reg_rdata_r[7:2] == 6'h00)
      else $error("irq upper bits set");
   a_irq_masked: assert property (reg_wr && reg_addr == 12'h481 && reg_wdata[1:0] == 2'h0 |=> !irq)
      else $error("irq while masked");
   a_code_thr_zero: assert property (reg_rd && reg_addr == 12'h46E && $past(reset_n)
      && $past(error_count_threshold) == 8'h00 |=> reg_rdata_r == 8'hFF) else $error("code flags not set");
   a_ctrl_thr_zero: assert property (reg_rd && reg_addr == 12'h46F && $past(reset_n)
      && $past(error_count_threshold) == 8'h00 |=> reg_rdata_r == 8'hFF) else $error("ctrl flags not set");
endmodule // lane_err_asserts
bind lane_code_error_status lane_err_asserts #(.CNT_W(CNT_W)) u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
   .error_count_threshold(error_count_threshold), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .irq(irq));

// file: tb/lane_code_error_status_bench.sv
`timescale 1ns/100ps
module lane_code_error_status_bench;
   logic ref_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, go = 0, link_page = 0, irq;
   logic [15:0] code_evt, ctrl_evt;
   logic [7:0] thr = 8'hFF, reg_wdata = 8'h00, reg_rdata_r, n = 8'h00, acc;
   logic [11:0] reg_addr = 12'h000;
   logic [4:0] sel = 5'h00;
   int num_errors = 0, num_checks = 0;
   initial forever #50 ref_clk = ~ref_clk;
   lane_code_error_status dut (.ref_clk(ref_clk), .reset_n(reset_n), .invalid_code_evt(code_evt),
      .stray_control_evt(ctrl_evt), .error_count_threshold(thr), .link_page(link_page), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .irq(irq));
   lane_err_src src (.ref_clk(ref_clk), .sel(sel), .n(n), .go(go), .code_evt(code_evt), .ctrl_evt(ctrl_evt));
   // Compare, count and report
   task chk(string what, logic [7:0] exp, logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One-cycle register write and read
   task wr(logic [11:0] a, logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1;
      @(posedge ref_clk);
      reg_wr <= 0;
      #1;
   endtask
   task rd(logic [11:0] a, logic [7:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1;
      @(posedge ref_clk);
      reg_rd <= 0;
      #1 chk($sformatf("reg %h", a), exp, reg_rdata_r);
   endtask
   // Burst of k errors on one class, link and lane
   task send(logic [4:0] s, logic [7:0] k);
      @(posedge ref_clk);
      sel <= s;
      n <= k;
      go <= 1;
      @(posedge ref_clk);
      go <= 0;
      repeat (k + 4) @(posedge ref_clk);
   endtask
   task wrap_up;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Watchdog
   initial begin
      #1000000;
      num_errors++;
      wrap_up;
   end
   // Test sequence
   initial begin
      repeat (8) @(posedge ref_clk);
      reset_n <= 1;
      rd(12'h46E, 8'h00);
      rd(12'h46F, 8'h00);
      rd(12'h123, 8'h00);
      wr(12'h46E, 8'hFF);
      rd(12'h46E, 8'h00);
      wr(12'h481, 8'hFF);
      rd(12'h481, 8'h03);
      $display("test reset done");
      @(posedge ref_clk) thr <= 8'h03;
      acc = 8'h00;
      for (int l = 0; l < 8; l++) begin
         send(l, 2);
         rd(12'h46E, acc);
         send(l, 1);
         acc[l] = 1;
         rd(12'h46E, acc);
      end
      send(5'h1F, 3);
      rd(12'h46F, 8'h00);
      @(posedge ref_clk) link_page <= 1;
      rd(12'h46F, 8'h80);
      rd(12'h46E, 8'h00);
      @(posedge ref_clk) link_page <= 0;
      $display("test lanes done");
      chk("irq", 8'h01, irq);
      rd(12'h480, 8'h03);
      wr(12'h480, 8'h03);
      rd(12'h480, 8'h00);
      chk("irq", 8'h00, irq);
      wr(12'h481, 8'h00);
      wr(12'h482, 8'h01);
      send(5'h00, 3);
      rd(12'h480, 8'h01);
      chk("irq", 8'h00, irq);
      wr(12'h481, 8'h01);
      chk("irq", 8'h01, irq);
      @(posedge ref_clk) thr <= 8'h00;
      rd(12'h46E, 8'hFF);
      rd(12'h46F, 8'hFF);
      $display("test irq done");
      wrap_up;
   end
endmodule // lane_code_error_status_bench
